// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic aclk, aresetn, ce, link_clk, serial_in, load_strobe, chain_out;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, bits;
    logic [3:0] s_axi_wstrb, bc_src;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [63:0] route_src;
    logic [15:0] out_drive_en, gain_x2, en_m, gain_m, inj_w;
    logic clamp_en, standby, bc_on, clamp_m, glob_m;
    logic [3:0] tbl[16];
    logic [33:0] rd_q[$];
    int mismatches, cmp_count;

    vxcfg_host_model i_host (.link_clk, .serial_in, .load_strobe, .chain_out);
    vxcfg_top i_dut (.aclk, .aresetn, .ce, .link_clk, .serial_in, .load_strobe, .chain_out,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .route_src, .out_drive_en, .gain_x2, .clamp_en,
        .standby);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tmo(input int n);
        if (n >= 100) begin
            mismatches++;
            $display("Error handshake expected answer seen none");
            end_sim;
        end
    endtask

    // bench view of the settings, built from the word formats
    task automatic apply(input logic [15:0] w);
        logic [3:0] nib;
        nib = {w[6], w[4], w[2], w[0]};
        case (w[15:13])
            vxcfg_pkg::CMD_MAP: tbl[w[4:1]] = w[12:9];
            vxcfg_pkg::CMD_ENABLE: en_m[w[9:8]*4 +: 4] = nib;
            vxcfg_pkg::CMD_GAIN: gain_m[w[9:8]*4 +: 4] = nib;
            vxcfg_pkg::CMD_BCAST: begin
                bc_on = w[0];
                bc_src = w[12:9];
            end
            vxcfg_pkg::CMD_CTRL: begin
                clamp_m = w[9];
                glob_m = w[0];
            end
            default: ;
        endcase
    endtask

    task automatic check_all;
        logic [63:0] r;
        // settled values, away from the edge that launches them
        @(negedge aclk);
        for (int i = 0; i < 16; i++) r[i*4 +: 4] = bc_on ? bc_src : tbl[i];
        chk("route_src", r, route_src);
        chk("out_drive_en", glob_m ? en_m : 16'h0, out_drive_en);
        chk("gain_x2", gain_m, gain_x2);
        chk("clamp_en", clamp_m, clamp_en);
        chk("standby", !glob_m, standby);
    endtask

    task automatic send_word(input logic [15:0] w);
        i_host.send({16'h0, w}, 16);
        apply(w);
        check_all;
    endtask

    function automatic logic [15:0] bw(logic [2:0] c, logic [1:0] b, logic [3:0] n);
        return {c, 3'h0, b, 1'b0, n[3], 1'b0, n[2], 1'b0, n[1], 1'b0, n[0]};
    endfunction

    // ready is sampled mid-cycle, where it already holds its value for the next edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic pa, pw, ta, tw, b;
        logic [1:0] rs;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        n = 0;
        while ((pa || pw) && n < 100) begin
            @(negedge aclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
            n++;
        end
        tmo(n);
        n = 0;
        b = 1'b0;
        while (!b && n < 100) begin
            @(negedge aclk);
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            n++;
        end
        tmo(n);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk("bresp", r, rs);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        logic t;
        int n;
        rd_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        t = 1'b0;
        n = 0;
        while (!t && n < 100) begin
            @(negedge aclk);
            t = s_axi_arready;
            n++;
        end
        tmo(n);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        t = 1'b0;
        n = 0;
        while (!t && n < 100) begin
            @(negedge aclk);
            t = s_axi_rvalid;
            n++;
        end
        tmo(n);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    // read answers are matched against the oldest noted expectation
    always @(negedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            if (rd_q.size() == 0) chk("rd_queue", 64'h1, 64'h0);
            else chk("read", rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        ce = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h3;
        {en_m, gain_m, bc_src, bc_on, clamp_m, glob_m} = '0;
        for (int i = 0; i < 16; i++) tbl[i] = 4'h0;
        mismatches = 0;
        cmp_count = 0;
        void'($urandom(39570));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check_all;
        chk("chain_out", 64'h0, chain_out);
        $display("test reset done");
        send_word(16'he201);
        for (int c = 1; c < 3; c++) begin
            for (int b = 0; b < 4; b++) send_word(bw(3'(c), 2'(b), 4'($urandom)));
        end
        send_word(16'he000);
        send_word(16'he001);
        $display("test banks done");
        for (int i = 0; i < 16; i++) send_word({3'h0, 4'($urandom), 4'h0, 4'(i), 1'b0});
        send_word({3'h0, tbl[3], 4'h0, 4'h9, 1'b0});
        for (int i = 0; i < 16; i++) begin
            axi_rd(8'(8'h40 + 4 * i), {vxcfg_pkg::RESP_OKAY, 28'h0, tbl[i]});
        end
        $display("test mapping done");
        send_word({3'h3, 4'h5, 8'h00, 1'b1});
        send_word({3'h3, 4'ha, 8'h00, 1'b0});
        for (int c = 4; c < 7; c++) send_word({3'(c), 13'($urandom)});
        $display("test broadcast done");
        @(posedge aclk);
        ce <= 1'b0;
        // frozen core must miss a whole frame and its strobe
        i_host.send({16'h0, 16'he000}, 16);
        @(posedge aclk);
        ce <= 1'b1;
        check_all;
        $display("test clock enable done");
        bits = $urandom;
        i_host.send(bits, 32);
        apply(bits[31:16]);
        check_all;
        for (int j = 16; j < 32; j++) chk("chain_out", bits[j-16], i_host.seen[j]);
        $display("test chain done");
        inj_w = bw(vxcfg_pkg::CMD_GAIN, 2'h2, 4'($urandom));
        axi_wr(vxcfg_pkg::OFS_INJECT, {16'h0, inj_w}, vxcfg_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        apply(inj_w);
        check_all;
        axi_rd(vxcfg_pkg::OFS_INJECT, {vxcfg_pkg::RESP_OKAY, 16'h0, inj_w});
        axi_rd(vxcfg_pkg::OFS_LAST, {vxcfg_pkg::RESP_OKAY, 16'h0, inj_w});
        axi_rd(8'h30, {vxcfg_pkg::RESP_SLVERR, 32'h0});
        axi_wr(vxcfg_pkg::OFS_STATUS, 32'h0000ffff, vxcfg_pkg::RESP_SLVERR);
        axi_wr(8'h44, 32'h0000000f, vxcfg_pkg::RESP_SLVERR);
        repeat (3) @(posedge aclk);
        check_all;
        $display("test register bus done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        {en_m, gain_m, bc_src, bc_on, clamp_m, glob_m} = '0;
        for (int i = 0; i < 16; i++) tbl[i] = 4'h0;
        check_all;
        chk("chain_out", 64'h0, chain_out);
        axi_rd(vxcfg_pkg::OFS_STATUS, {vxcfg_pkg::RESP_OKAY, 32'h4});
        for (int i = 0; i < 16; i++) begin
            axi_rd(8'(8'h40 + 4 * i), {vxcfg_pkg::RESP_OKAY, 32'h0});
        end
        check_all;
        $display("test second reset done");
        end_sim;
    end
endmodule

// >>> vxcfg_host_model.sv
`timescale 1ns/1ps
module vxcfg_host_model (
    // link pins
    output logic link_clk,
    output logic serial_in,
    output logic load_strobe,
    // daisy-chain return
    input wire logic chain_out
);
    logic [31:0] seen;
    initial begin
        link_clk = 1'b0;
        serial_in = 1'b0;
        load_strobe = 1'b0;
        seen = '0;
    end
    // offset of 7 ns keeps link edges off the sampling clock edges
    task automatic send(input logic [31:0] bits, input int n);
        #7;
        for (int i = 0; i < n; i++) begin
            serial_in = bits[i];
            #100 link_clk = 1'b1;
            #100 seen[i] = chain_out;
            #100 link_clk = 1'b0;
            #100;
        end
        #100 load_strobe = 1'b1;
        // no stale bit left on the line after the frame
        serial_in = ~bits[n-1];
        #400 load_strobe = 1'b0;
        #400;
    endtask
endmodule

// >>> vxcfg_mem_if.sv
`timescale 1ns/1ps
interface vxcfg_mem_if;
    logic wr_en;
    logic [3:0] wr_addr;
    logic [3:0] wr_data;
    logic [3:0] rd_addr;
    logic [3:0] rd_data;
    logic [63:0] contents;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data, input contents);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data, output contents);
endinterface

// >>> vxcfg_pkg.sv
package vxcfg_pkg;
    localparam int WORD_W = 16;
    localparam int N_OUT = 16;
    localparam int SEL_W = 4;
    localparam int ADDR_W = 8;
    // command code field
    localparam int CMD_HI = 15;
    localparam int CMD_LO = 13;
    localparam logic [2:0] CMD_MAP = 3'h0;
    localparam logic [2:0] CMD_ENABLE = 3'h1;
    localparam logic [2:0] CMD_GAIN = 3'h2;
    localparam logic [2:0] CMD_BCAST = 3'h3;
    localparam logic [2:0] CMD_CTRL = 3'h7;
    // word fields
    localparam int SRC_HI = 12;
    localparam int SRC_LO = 9;
    localparam int DST_HI = 4;
    localparam int DST_LO = 1;
    localparam int BANK_HI = 9;
    localparam int BANK_LO = 8;
    localparam int CLAMP_BIT = 9;
    localparam int GLOBAL_BIT = 0;
    localparam int BCAST_BIT = 0;
    // register map, byte addresses
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_INJECT = 8'h04;
    localparam logic [7:0] OFS_LAST = 8'h08;
    localparam logic [7:0] OFS_ENABLES = 8'h0c;
    localparam logic [1:0] ROUTE_REGION = 2'h1;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RST_MASK = 16'h0000;
    localparam logic [3:0] RST_SRC = 4'h0;
    localparam logic RST_STANDBY = 1'b1;
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_WAIT = 3'b010,
        RD_RESP = 3'b100
    } vxcfg_rd_state_t;
endpackage

// >>> vxcfg_route_mem.sv
`timescale 1ns/1ps
module vxcfg_route_mem (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // table port
    vxcfg_mem_if.mem port
);
    logic [3:0] word_reg [16];
    logic [3:0] rd_data_reg;

    // table cleared at reset so every output starts on input 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 16; i++) begin
                word_reg[i] <= vxcfg_pkg::RST_SRC;
            end
        end else if (ce && port.wr_en) begin
            word_reg[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_data_reg <= vxcfg_pkg::RST_SRC;
        end else if (ce) begin
            rd_data_reg <= word_reg[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_reg;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            port.contents[i*4 +: 4] = word_reg[i];
        end
    end
endmodule

// >>> vxcfg_top.sv
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - shift serial input on every link rise
// - least significant bit first, bit 15 last
// - latch strobe rise applies the shifted word
// - chain output is input delayed 15.5 clocks
// - no readback on chain output
// - chained devices all update on one strobe
// - bits 15..13 select the command
// - mapping word routes source to destination
// - one input may feed many outputs
// - enable word: bank bits, four enable bits
// - output drives only with global enable
// - gain word like enable, set means two
// - broadcast word drives all outputs one source
// - stored routing returns when broadcast ends
// - control word sets clamp, standby, global
// - reset disables outputs, enters standby
// - control bit 9 clamp, bit 0 global
module vxcfg_top (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // serial link pins
    input wire logic link_clk,
    input wire logic serial_in,
    input wire logic load_strobe,
    output logic chain_out,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // matrix settings
    output logic [63:0] route_src,
    output logic [15:0] out_drive_en,
    output logic [15:0] gain_x2,
    output logic clamp_en,
    output logic standby
);
    logic [2:0] clk_sync_reg;
    logic [1:0] sin_sync_reg;
    logic [2:0] ld_sync_reg;
    logic link_rise, link_fall, ld_rise, apply, wr_go;
    logic [15:0] shift_reg, shift_next, word_next;
    logic chain_reg;
    logic [2:0] cmd;
    logic [15:0] en_reg, gain_reg, last_reg, inj_word_reg, drive_reg;
    logic global_reg, clamp_reg, standby_reg, bcast_reg, inj_pend_reg;
    logic [3:0] bsrc_reg;
    logic [63:0] route_reg;
    logic aw_have_reg, w_have_reg, bvalid_reg;
    logic [7:0] aw_addr_reg, ar_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    vxcfg_pkg::vxcfg_rd_state_t rd_state;

    vxcfg_mem_if mem_bus ();
    vxcfg_route_mem u_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .port(mem_bus.mem)
    );

    function automatic logic [15:0] bank_update(input logic [15:0] cur,
                                                input logic [15:0] w);
        logic [15:0] res;
        res = cur;
        for (int k = 0; k < 4; k++) begin
            res[{w[vxcfg_pkg::BANK_HI:vxcfg_pkg::BANK_LO], 2'(k)}] = w[2*k];
        end
        return res;
    endfunction

    function automatic logic is_route(input logic [7:0] a);
        return a[7:6] == vxcfg_pkg::ROUTE_REGION && a[1:0] == 2'h0;
    endfunction

    // link pins are asynchronous to aclk; edges read from the second stage on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_sync_reg <= 3'h0;
            sin_sync_reg <= 2'h0;
            ld_sync_reg <= 3'h0;
        end else if (ce) begin
            clk_sync_reg <= {clk_sync_reg[1:0], link_clk};
            sin_sync_reg <= {sin_sync_reg[0], serial_in};
            ld_sync_reg <= {ld_sync_reg[1:0], load_strobe};
        end
    end
    assign link_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
    assign link_fall = ~clk_sync_reg[1] & clk_sync_reg[2];
    assign ld_rise = ld_sync_reg[1] & ~ld_sync_reg[2];

    // new bit enters at the top, so the first bit ends in bit 0
    assign shift_next = {sin_sync_reg[1], shift_reg[15:1]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_reg <= vxcfg_pkg::RST_WORD;
        end else if (ce && link_rise) begin
            shift_reg <= shift_next;
        end
    end

    // bit 0 is the bit taken 15 rises ago; it leaves on the next fall
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chain_reg <= 1'b0;
        end else if (ce && link_fall) begin
            chain_reg <= shift_reg[0];
        end
    end
    assign chain_out = chain_reg;

    // strobe may be seen in the same aclk cycle as the last rise
    always_comb begin
        if (ld_rise) begin
            word_next = link_rise ? shift_next : shift_reg;
        end else begin
            word_next = inj_word_reg;
        end
    end
    assign apply = ld_rise | inj_pend_reg;
    assign cmd = word_next[vxcfg_pkg::CMD_HI:vxcfg_pkg::CMD_LO];

    // mapping words go straight to the table, broadcast or not
    assign mem_bus.wr_en = ce && apply && cmd == vxcfg_pkg::CMD_MAP;
    assign mem_bus.wr_addr = word_next[vxcfg_pkg::DST_HI:vxcfg_pkg::DST_LO];
    assign mem_bus.wr_data = word_next[vxcfg_pkg::SRC_HI:vxcfg_pkg::SRC_LO];
    assign mem_bus.rd_addr = ar_addr_reg[5:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_reg <= vxcfg_pkg::RST_MASK;
            gain_reg <= vxcfg_pkg::RST_MASK;
            global_reg <= 1'b0;
            clamp_reg <= 1'b0;
            standby_reg <= vxcfg_pkg::RST_STANDBY;
            bcast_reg <= 1'b0;
            bsrc_reg <= vxcfg_pkg::RST_SRC;
            last_reg <= vxcfg_pkg::RST_WORD;
        end else if (ce && apply) begin
            last_reg <= word_next;
            case (cmd)
                vxcfg_pkg::CMD_ENABLE: begin
                    en_reg <= bank_update(en_reg, word_next);
                end
                vxcfg_pkg::CMD_GAIN: begin
                    gain_reg <= bank_update(gain_reg, word_next);
                end
                vxcfg_pkg::CMD_BCAST: begin
                    bcast_reg <= word_next[vxcfg_pkg::BCAST_BIT];
                    bsrc_reg <= word_next[vxcfg_pkg::SRC_HI:vxcfg_pkg::SRC_LO];
                end
                vxcfg_pkg::CMD_CTRL: begin
                    clamp_reg <= word_next[vxcfg_pkg::CLAMP_BIT];
                    global_reg <= word_next[vxcfg_pkg::GLOBAL_BIT];
                    standby_reg <= ~word_next[vxcfg_pkg::GLOBAL_BIT];
                end
                default: ;
            endcase
        end
    end

    // effective routing and drive enables, one cycle behind the stored state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_reg <= 64'h0;
            drive_reg <= vxcfg_pkg::RST_MASK;
        end else if (ce) begin
            route_reg <= bcast_reg ? {16{bsrc_reg}} : mem_bus.contents;
            drive_reg <= en_reg & {16{global_reg}};
        end
    end
    assign route_src = route_reg;
    assign out_drive_en = drive_reg;
    assign gain_x2 = gain_reg;
    assign clamp_en = clamp_reg;
    assign standby = standby_reg;

    // write channel: address and data taken in either order
    assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_have_reg & ~bvalid_reg;
    assign wr_go = aw_have_reg & w_have_reg & ~bvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_go) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= vxcfg_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= aw_addr_reg == vxcfg_pkg::OFS_INJECT ?
                             vxcfg_pkg::RESP_OKAY : vxcfg_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // injected word waits while a serial strobe takes the apply slot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inj_pend_reg <= 1'b0;
            inj_word_reg <= vxcfg_pkg::RST_WORD;
        end else if (ce) begin
            if (wr_go && aw_addr_reg == vxcfg_pkg::OFS_INJECT) begin
                inj_pend_reg <= 1'b1;
                if (w_strb_reg[0]) begin
                    inj_word_reg[7:0] <= w_data_reg[7:0];
                end
                if (w_strb_reg[1]) begin
                    inj_word_reg[15:8] <= w_data_reg[15:8];
                end
            end else if (!ld_rise) begin
                inj_pend_reg <= 1'b0;
            end
        end
    end

    // read: one wait cycle lets the table memory register its word
    assign s_axi_arready = rd_state == vxcfg_pkg::RD_IDLE;
    assign s_axi_rvalid = rd_state == vxcfg_pkg::RD_RESP;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = is_route(ar_addr_reg) ? {28'h0, mem_bus.rd_data} : rdata_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= vxcfg_pkg::RD_IDLE;
            ar_addr_reg <= 8'h00;
        end else if (ce) begin
            case (rd_state)
                vxcfg_pkg::RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        ar_addr_reg <= s_axi_araddr;
                        rd_state <= vxcfg_pkg::RD_WAIT;
                    end
                end
                vxcfg_pkg::RD_WAIT: begin
                    rd_state <= vxcfg_pkg::RD_RESP;
                end
                vxcfg_pkg::RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state <= vxcfg_pkg::RD_IDLE;
                    end
                end
                default: begin
                    rd_state <= vxcfg_pkg::RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_reg <= 32'h0;
            rresp_reg <= vxcfg_pkg::RESP_OKAY;
        end else if (ce && rd_state == vxcfg_pkg::RD_WAIT) begin
            rresp_reg <= vxcfg_pkg::RESP_OKAY;
            rdata_reg <= 32'h0;
            case (ar_addr_reg)
                vxcfg_pkg::OFS_STATUS: begin
                    rdata_reg[8:0] <= {bsrc_reg, bcast_reg, global_reg,
                                       standby_reg, clamp_reg, inj_pend_reg};
                end
                vxcfg_pkg::OFS_INJECT: rdata_reg[15:0] <= inj_word_reg;
                vxcfg_pkg::OFS_LAST: rdata_reg[15:0] <= last_reg;
                vxcfg_pkg::OFS_ENABLES: rdata_reg <= {gain_reg, en_reg};
                default: begin
                    if (!is_route(ar_addr_reg)) begin
                        rresp_reg <= vxcfg_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
    end

    chk_shift_rise: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && link_rise |=> shift_reg == {$past(sin_sync_reg[1]), $past(shift_reg[15:1])})
        else $error("shift register missed a link rise");
    chk_chain_fall: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && link_fall |=> chain_out == $past(shift_reg[0]) ##1 $stable(chain_out) || link_fall)
        else $error("chain output not taken from bit 0 on fall");
    chk_no_apply_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !apply |=> $stable(en_reg) && $stable(gain_reg) && $stable(bcast_reg))
        else $error("settings changed without a strobe");
    chk_drive_and: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> out_drive_en == ($past(en_reg) & {16{$past(global_reg)}}))
        else $error("drive enable not gated by global enable");
    chk_bcast_all: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && bcast_reg |=> route_src == {16{$past(bsrc_reg)}})
        else $error("broadcast source not on every output");
    chk_bcast_restore: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !bcast_reg |=> route_src == $past(mem_bus.contents))
        else $error("stored routing not restored");
    chk_reserved_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && apply && cmd inside {3'h4, 3'h5, 3'h6} |=>
        $stable(clamp_reg) && $stable(global_reg) && $stable(en_reg) && $stable(bsrc_reg))
        else $error("reserved command changed settings");
    chk_ctrl_fields: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && apply && cmd == vxcfg_pkg::CMD_CTRL |=>
        clamp_en == $past(word_next[9]) && global_reg == $past(word_next[0]))
        else $error("control word fields misplaced");
    chk_map_write: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && apply && cmd == vxcfg_pkg::CMD_MAP |-> mem_bus.wr_en &&
        mem_bus.wr_addr == word_next[4:1] && mem_bus.wr_data == word_next[12:9])
        else $error("mapping word fields misplaced");
    chk_reset_state: assert property (@(posedge aclk)
        $rose(aresetn) |-> standby && out_drive_en == 16'h0 && !clamp_en)
        else $error("outputs not disabled after reset");
endmodule
